// >>> common/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

`define GPIO_PIN_COUNT    32
`define GPIO_HALF_PORT    8
`define GPIO_PERIPH_COUNT 4

// block select, address bits 11:8
`define BLK_PORT          4'h0
`define BLK_GPIO_IRQ      4'h1
`define BLK_CHAN_BASE     4'h2

// port block, byte offsets
`define PORT_DATA         8'h00
`define PORT_DATA_SET     8'h04
`define PORT_DATA_CLR     8'h08
`define PORT_DATA_TGL     8'h0C
`define PORT_DIR          8'h10
`define PORT_DIR_SET      8'h14
`define PORT_DIR_CLR      8'h18
`define PORT_INEN         8'h1C
`define PORT_FUNC_EN      8'h20
`define PORT_MUX_LO       8'h24
`define PORT_MUX_HI       8'h28
`define PORT_PIN_STATE    8'h2C

// interrupt unit block, byte offsets
`define IRQ_MASK          8'h00
`define IRQ_MASK_SET      8'h04
`define IRQ_MASK_CLR      8'h08
`define IRQ_REQ           8'h0C
`define IRQ_LATCH         8'h10
`define IRQ_EDGE_SET      8'h14
`define IRQ_EDGE_CLR      8'h18
`define IRQ_BOTH_SET      8'h1C
`define IRQ_BOTH_CLR      8'h20
`define IRQ_POL_SET       8'h24
`define IRQ_POL_CLR       8'h28
`define IRQ_PIN_STATE     8'h2C
`define IRQ_ASSIGN        8'h30
`define IRQ_SW_TRIG       8'h34

// reset values
`define RST_WORD          32'h0000_0000
`define RST_ASSIGN        8'hE4

`endif

// >>> common/gpio_pkg.sv
package gpio_pkg;

	typedef struct packed {
		logic [31:0] data;
		logic [31:0] oe;
		logic [31:0] ie;
	} lane_type;

	typedef enum logic [2:0] {
		WR_NONE = 3'b001,
		WR_SET  = 3'b010,
		WR_CLR  = 3'b100
	} wr_mode_type;

endpackage

// >>> src/pin_irq_unit.sv
`timescale 1ns/1ps
`include "gpio_map.svh"

module pin_irq_unit (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr_stb,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic [31:0] pins,
	input  wire logic [31:0] hw_allow,
	output logic      [31:0] rd_word,
	output logic      [7:0]  route,
	output logic             irq
);

	logic [31:0] mask_reg;
	logic [31:0] edge_reg;
	logic [31:0] both_reg;
	logic [31:0] pol_reg;
	logic [31:0] latch_reg;
	logic [31:0] prev_reg;
	logic [7:0]  route_reg;
	logic        irq_reg;

	function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] val,
		input gpio_pkg::wr_mode_type mode);
		case (mode)
			gpio_pkg::WR_SET: set_clr = cur | val;
			gpio_pkg::WR_CLR: set_clr = cur & ~val;
			default:          set_clr = cur;
		endcase
	endfunction

	function automatic gpio_pkg::wr_mode_type alias_mode(input logic s, input logic c);
		alias_mode = s ? gpio_pkg::WR_SET : (c ? gpio_pkg::WR_CLR : gpio_pkg::WR_NONE);
	endfunction

	wire w_mask_s  = wr_stb && addr == `IRQ_MASK_SET;
	wire w_mask_c  = wr_stb && addr == `IRQ_MASK_CLR;
	wire w_edge_s  = wr_stb && addr == `IRQ_EDGE_SET;
	wire w_edge_c  = wr_stb && addr == `IRQ_EDGE_CLR;
	wire w_both_s  = wr_stb && addr == `IRQ_BOTH_SET;
	wire w_both_c  = wr_stb && addr == `IRQ_BOTH_CLR;
	wire w_pol_s   = wr_stb && addr == `IRQ_POL_SET;
	wire w_pol_c   = wr_stb && addr == `IRQ_POL_CLR;
	wire w_ack     = wr_stb && (addr == `IRQ_REQ || addr == `IRQ_LATCH);
	wire w_assign  = wr_stb && addr == `IRQ_ASSIGN;
	wire w_trig    = wr_stb && addr == `IRQ_SW_TRIG;

	// a polarity change can itself look like an edge; mask first when retuning
	wire [31:0] active   = pins ^ pol_reg;
	wire [31:0] rise     = active & ~prev_reg;
	wire [31:0] fall     = prev_reg & ~active;
	wire [31:0] edge_ev  = (rise | (both_reg & fall)) & edge_reg & hw_allow;
	wire [31:0] level_ev = active & ~edge_reg & hw_allow;
	wire [31:0] sw_ev    = w_trig ? wr_data : `RST_WORD;
	wire [31:0] clr_bits = w_ack ? wr_data : `RST_WORD;
	// set beats clear in the same cycle
	wire [31:0] latch_next = (edge_reg & (latch_reg & ~clr_bits)) | edge_ev | level_ev | sw_ev;
	wire [31:0] mask_next  = set_clr(mask_reg, wr_data, alias_mode(w_mask_s, w_mask_c));

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_reg  <= `RST_WORD;
			edge_reg  <= `RST_WORD;
			both_reg  <= `RST_WORD;
			pol_reg   <= `RST_WORD;
			latch_reg <= `RST_WORD;
			prev_reg  <= `RST_WORD;
			route_reg <= `RST_ASSIGN;
			irq_reg   <= 1'b0;
		end else begin
			mask_reg  <= mask_next;
			edge_reg  <= set_clr(edge_reg, wr_data, alias_mode(w_edge_s, w_edge_c));
			both_reg  <= set_clr(both_reg, wr_data, alias_mode(w_both_s, w_both_c));
			pol_reg   <= set_clr(pol_reg, wr_data, alias_mode(w_pol_s, w_pol_c));
			latch_reg <= latch_next;
			prev_reg  <= active;
			irq_reg   <= |(latch_next & mask_next);
			if (w_assign) begin
				route_reg <= wr_data[7:0];
			end
		end
	end

	always_comb begin
		case (addr)
			`IRQ_MASK, `IRQ_MASK_SET, `IRQ_MASK_CLR: rd_word = mask_reg;
			`IRQ_REQ:                                rd_word = latch_reg & mask_reg;
			`IRQ_LATCH:                              rd_word = latch_reg;
			`IRQ_EDGE_SET, `IRQ_EDGE_CLR:            rd_word = edge_reg;
			`IRQ_BOTH_SET, `IRQ_BOTH_CLR:            rd_word = both_reg;
			`IRQ_POL_SET, `IRQ_POL_CLR:              rd_word = pol_reg;
			`IRQ_PIN_STATE:                          rd_word = pins;
			`IRQ_ASSIGN:                             rd_word = {24'h00_0000, route_reg};
			default:                                 rd_word = `RST_WORD;
		endcase
	end

	assign route = route_reg;
	assign irq   = irq_reg;

endmodule

// >>> src/gpio_port.sv
// Functional notes
// - each pin has its own direction bit choosing input or output.
// - set, clear and toggle aliases change only pins whose written bit is one.
// - a per-pin mask decides whether a pin may interrupt the processor.
// - at the gpio interrupt unit, input pins interrupt from pin activity, output pins only by software trigger.
// - a per-pin bit picks level or edge, and in edge mode rising only or both edges.
// - every pin can request in edge or level fashion with software polarity.
// - channel detection watches the pin level whatever the pin is used for.
// - each channel handles 32 pin inputs as bit positions of its own registers.
// - pins join channels in half ports of eight, each lane routed by software.
// - each channel has an 8-bit routing register and 32-bit registers for masking, pending and clearing.
// - pin states and latches read back whether or not masked.
// - data, direction, mask, edge, both-edge and polarity registers have set and clear aliases acting on written ones.
// - each pin carries the gpio function or one of four peripheral functions.
// - with output and input enable both active, outgoing data loops back to receive.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "gpio_map.svh"

module gpio_port #(
	parameter int CHAN_COUNT = 3
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [11:0]              addr,
	input  wire logic [31:0]              wr_data,
	input  wire logic                     wr_stb,
	input  wire logic                     rd_stb,
	output logic      [31:0]              rd_data,
	input  wire logic [31:0]              pad_in,
	output logic      [31:0]              pad_out,
	output logic      [31:0]              pad_oe,
	input  gpio_pkg::lane_type [3:0]      periph_drive,
	output logic      [3:0][31:0]         periph_in,
	output logic                          gpio_irq,
	output logic      [CHAN_COUNT-1:0]    chan_irq
);

	localparam int NP = `GPIO_PIN_COUNT;
	localparam int HP = `GPIO_HALF_PORT;

	logic [31:0]          data_reg;
	logic [31:0]          dir_reg;
	logic [31:0]          inen_reg;
	logic [31:0]          func_reg;
	logic [31:0]          mux_lo_reg;
	logic [31:0]          mux_hi_reg;
	logic [31:0]          pad_meta_reg;
	logic [31:0]          pad_sync_reg;
	logic [31:0]          pad_out_reg;
	logic [31:0]          pad_oe_reg;
	logic [3:0][31:0]     periph_in_reg;
	logic [31:0]          rd_data_reg;

	function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] val,
		input gpio_pkg::wr_mode_type mode);
		case (mode)
			gpio_pkg::WR_SET: set_clr = cur | val;
			gpio_pkg::WR_CLR: set_clr = cur & ~val;
			default:          set_clr = cur;
		endcase
	endfunction

	function automatic logic [1:0] pin_sel(input logic [31:0] lo, input logic [31:0] hi, input int p);
		logic [63:0] all;
		all     = {hi, lo};
		pin_sel = all[2*p +: 2];
	endfunction

	// address decode
	wire [3:0] blk      = addr[11:8];
	wire [7:0] off      = addr[7:0];
	wire       port_wr  = wr_stb && blk == `BLK_PORT;
	wire       w_data   = port_wr && off == `PORT_DATA;
	wire       w_dset   = port_wr && off == `PORT_DATA_SET;
	wire       w_dclr   = port_wr && off == `PORT_DATA_CLR;
	wire       w_dtgl   = port_wr && off == `PORT_DATA_TGL;
	wire       w_dir    = port_wr && off == `PORT_DIR;
	wire       w_dirs   = port_wr && off == `PORT_DIR_SET;
	wire       w_dirc   = port_wr && off == `PORT_DIR_CLR;
	wire       w_inen   = port_wr && off == `PORT_INEN;
	wire       w_func   = port_wr && off == `PORT_FUNC_EN;
	wire       w_mux_lo = port_wr && off == `PORT_MUX_LO;
	wire       w_mux_hi = port_wr && off == `PORT_MUX_HI;

	wire gpio_pkg::wr_mode_type data_mode = w_dset ? gpio_pkg::WR_SET :
		(w_dclr ? gpio_pkg::WR_CLR : gpio_pkg::WR_NONE);
	wire gpio_pkg::wr_mode_type dir_mode  = w_dirs ? gpio_pkg::WR_SET :
		(w_dirc ? gpio_pkg::WR_CLR : gpio_pkg::WR_NONE);

	// whole-word write, else only the written ones change
	wire [31:0] data_next = w_data ? wr_data :
		(w_dtgl ? data_reg ^ wr_data : set_clr(data_reg, wr_data, data_mode));
	wire [31:0] dir_next  = w_dir ? wr_data : set_clr(dir_reg, wr_data, dir_mode);

	// pin multiplexer
	logic [31:0] mux_out;
	logic [31:0] mux_oe;
	logic [31:0] mux_ie;
	logic [31:0] rx;
	logic [3:0][31:0] periph_next;

	always_comb begin
		for (int p = 0; p < NP; p++) begin
			logic [1:0] s;
			s = pin_sel(mux_lo_reg, mux_hi_reg, p);
			if (func_reg[p]) begin
				mux_out[p] = periph_drive[s].data[p];
				mux_oe[p]  = periph_drive[s].oe[p];
				mux_ie[p]  = periph_drive[s].ie[p];
			end else begin
				mux_out[p] = data_reg[p];
				mux_oe[p]  = dir_reg[p];
				mux_ie[p]  = inen_reg[p];
			end
			// bypass ahead of the pad driver
			rx[p] = (mux_oe[p] && mux_ie[p]) ? mux_out[p] : pad_sync_reg[p];
			for (int k = 0; k < `GPIO_PERIPH_COUNT; k++) begin
				periph_next[k][p] = func_reg[p] && s == k[1:0] && mux_ie[p] && rx[p];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			data_reg      <= `RST_WORD;
			dir_reg       <= `RST_WORD;
			inen_reg      <= `RST_WORD;
			func_reg      <= `RST_WORD;
			mux_lo_reg    <= `RST_WORD;
			mux_hi_reg    <= `RST_WORD;
			pad_meta_reg  <= `RST_WORD;
			pad_sync_reg  <= `RST_WORD;
			pad_out_reg   <= `RST_WORD;
			pad_oe_reg    <= `RST_WORD;
			periph_in_reg <= '0;
		end else begin
			data_reg      <= data_next;
			dir_reg       <= dir_next;
			if (w_inen) begin
				inen_reg <= wr_data;
			end
			if (w_func) begin
				func_reg <= wr_data;
			end
			if (w_mux_lo) begin
				mux_lo_reg <= wr_data;
			end
			if (w_mux_hi) begin
				mux_hi_reg <= wr_data;
			end
			pad_meta_reg  <= pad_in;
			pad_sync_reg  <= pad_meta_reg;
			pad_out_reg   <= mux_out;
			pad_oe_reg    <= mux_oe;
			periph_in_reg <= periph_next;
		end
	end

	// gpio interrupt unit: inputs from the pin, outputs by software only
	logic [31:0] gpio_irq_word;
	logic        gpio_irq_int;

	pin_irq_unit u_gpio_irq (
		.clk      (clk),
		.rst      (rst),
		.wr_stb   (wr_stb && blk == `BLK_GPIO_IRQ),
		.addr     (off),
		.wr_data  (wr_data),
		.pins     (rx),
		.hw_allow (~dir_reg),
		.rd_word  (gpio_irq_word),
		.route    (),
		.irq      (gpio_irq_int)
	);

	// pin interrupt channels, each a 32-bit view of four routed half ports
	logic [CHAN_COUNT-1:0][31:0] chan_word;
	logic [CHAN_COUNT-1:0][7:0]  chan_route;
	logic [CHAN_COUNT-1:0][31:0] chan_pins;
	logic [CHAN_COUNT-1:0]       chan_irq_int;

	genvar c;
	generate
		for (c = 0; c < CHAN_COUNT; c++) begin : g_chan
			localparam logic [3:0] CBLK = 4'(`BLK_CHAN_BASE + c);
			for (genvar b = 0; b < NP / HP; b++) begin : g_lane
				assign chan_pins[c][b*HP +: HP] = rx[chan_route[c][2*b +: 2]*HP +: HP];
			end
			pin_irq_unit u_chan (
				.clk      (clk),
				.rst      (rst),
				.wr_stb   (wr_stb && blk == CBLK),
				.addr     (off),
				.wr_data  (wr_data),
				.pins     (chan_pins[c]),
				.hw_allow (32'hFFFF_FFFF),
				.rd_word  (chan_word[c]),
				.route    (chan_route[c]),
				.irq      (chan_irq_int[c])
			);
		end
	endgenerate

	// read mux, answered in the next cycle; unmapped reads give zero
	logic [31:0] port_word;
	logic [31:0] rd_next;

	always_comb begin
		case (off)
			`PORT_DATA, `PORT_DATA_SET, `PORT_DATA_CLR, `PORT_DATA_TGL: port_word = data_reg;
			`PORT_DIR, `PORT_DIR_SET, `PORT_DIR_CLR:                     port_word = dir_reg;
			`PORT_INEN:                                                  port_word = inen_reg;
			`PORT_FUNC_EN:                                               port_word = func_reg;
			`PORT_MUX_LO:                                                port_word = mux_lo_reg;
			`PORT_MUX_HI:                                                port_word = mux_hi_reg;
			`PORT_PIN_STATE:                                             port_word = rx;
			default:                                                     port_word = `RST_WORD;
		endcase
		rd_next = `RST_WORD;
		if (blk == `BLK_PORT) begin
			rd_next = port_word;
		end else if (blk == `BLK_GPIO_IRQ) begin
			rd_next = gpio_irq_word;
		end
		for (int k = 0; k < CHAN_COUNT; k++) begin
			if (blk == 4'(`BLK_CHAN_BASE + k)) begin
				rd_next = chan_word[k];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_reg <= `RST_WORD;
		end else begin
			rd_data_reg <= rd_stb ? rd_next : `RST_WORD;
		end
	end

	assign rd_data   = rd_data_reg;
	assign pad_out   = pad_out_reg;
	assign pad_oe    = pad_oe_reg;
	assign periph_in = periph_in_reg;
	assign gpio_irq  = gpio_irq_int;
	assign chan_irq  = chan_irq_int;

endmodule

// >>> verif/gpio_port_properties.sv
`timescale 1ns/1ps
`include "gpio_map.svh"

module gpio_port_checker #(
	parameter int CHAN_COUNT = 3
) (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic [11:0]      addr,
	input wire logic [31:0]      wr_data,
	input wire logic             wr_stb,
	input wire logic             rd_stb,
	input wire logic [31:0]      rd_data,
	input wire logic [31:0]      pad_out,
	input wire logic [31:0]      pad_oe,
	input wire logic [3:0][31:0] periph_in,
	input wire logic             gpio_irq
);
	logic [31:0] func_reg;
	wire         w_func = wr_stb && addr == {`BLK_PORT, `PORT_FUNC_EN};
	wire         w_dset = wr_stb && addr == {`BLK_PORT, `PORT_DIR_SET};
	wire         w_dclr = wr_stb && addr == {`BLK_PORT, `PORT_DATA_CLR};
	wire         w_tgl  = wr_stb && addr == {`BLK_PORT, `PORT_DATA_TGL};
	wire         w_mclr = wr_stb && addr == {`BLK_GPIO_IRQ, `IRQ_MASK_CLR} && wr_data == 32'hFFFF_FFFF;
	// pins owned by the gpio function, shadowed from bus writes
	wire [31:0]  gp     = ~func_reg;
	wire [31:0]  rx_any = periph_in[0] | periph_in[1] | periph_in[2] | periph_in[3];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	always_ff @(posedge clk) begin
		if (rst) begin
			func_reg <= 32'h0000_0000;
		end else if (w_func) begin
			func_reg <= wr_data;
		end
	end

	sequence s_mask_all;
		wr_stb && addr == {`BLK_GPIO_IRQ, `IRQ_MASK_SET} && wr_data == 32'hFFFF_FFFF;
	endsequence
	sequence s_trig;
		wr_stb && addr == {`BLK_GPIO_IRQ, `IRQ_SW_TRIG} && wr_data != 32'h0000_0000;
	endsequence

	a_idle_read_zero: assert property (!rd_stb |=> rd_data == 32'h0000_0000)
		else $error("read data not zero outside answer");
	a_unmapped_zero: assert property (rd_stb && addr[11:8] > 4'(CHAN_COUNT + 1) |=> rd_data == 0)
		else $error("unmapped block read not zero");
	a_dir_set_pins: assert property (w_dset |-> ##2 ((pad_oe & $past(wr_data, 2) & gp) == ($past(wr_data, 2) & gp)))
		else $error("direction set missed a pin");
	a_data_clr_pins: assert property (w_dclr |-> ##2 ((pad_out & $past(wr_data, 2) & gp) == 0))
		else $error("data clear missed a pin");
	a_toggle_pins: assert property (w_tgl |-> ##2 (((pad_out ^ $past(pad_out)) & gp) == ($past(wr_data, 2) & gp)))
		else $error("toggle changed wrong pins");
	a_periph_gated: assert property ((rx_any & gp & ~$past(func_reg) & ~$past(func_reg, 2)) == 0)
		else $error("peripheral saw a gpio pin");
	a_sw_irq_up: assert property (s_mask_all ##2 s_trig |=> gpio_irq)
		else $error("software trigger raised no interrupt");
	a_mask_irq_off: assert property (w_mclr |=> !gpio_irq)
		else $error("masked interrupt still high");
endmodule

// >>> verif/pad_model.sv
`timescale 1ns/1ps

module pad_model (
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oe,
	input wire logic [31:0] ext_level,
	input wire logic [31:0] ext_fight,
	output logic     [31:0] pad_in
);
	// a fighting driver wins the pad, so only loopback can show pad_out
	wire [31:0] own = pad_oe & ~ext_fight;
	assign pad_in = (own & pad_out) | (~own & ext_level);
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`include "gpio_map.svh"
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x); end end

module tb_top;
	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	logic [11:0]              addr = '0;
	logic [31:0]              wr_data = '0;
	logic                     wr_stb = 1'b0;
	logic                     rd_stb = 1'b0;
	logic [31:0]              rd_data, pad_in, pad_out, pad_oe, d, x, em;
	logic [31:0]              ext_level = '0;
	logic [31:0]              ext_fight = '0;
	gpio_pkg::lane_type [3:0] periph_drive = '0;
	logic [3:0][31:0]         periph_in;
	logic                     gpio_irq;
	logic [2:0]               chan_irq;
	logic [31:0]              exp_q[$];
	logic                     rd_pend = 1'b0;
	int                       checked = 0;
	int                       miscompares = 0;
	int                       seed = 32'hdc99;

	always #12.5 clk = ~clk;

	gpio_port #(.CHAN_COUNT(3)) DUT (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rd_data(rd_data), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.periph_drive(periph_drive), .periph_in(periph_in), .gpio_irq(gpio_irq), .chan_irq(chan_irq));
	pad_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .ext_fight(ext_fight),
		.pad_in(pad_in));

	function automatic logic [11:0] pa(input logic [7:0] o);
		return {`BLK_PORT, o};
	endfunction
	function automatic logic [11:0] ga(input logic [7:0] o);
		return {`BLK_GPIO_IRQ, o};
	endfunction
	function automatic logic [11:0] ca(input logic [3:0] c, input logic [7:0] o);
		return {`BLK_CHAN_BASE + c, o};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(v);
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask
	// two sync flops, latch and irq flop, plus margin
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// answer stands only in the cycle after the strobe
	always @(posedge clk) rd_pend <= rd_stb;
	always @(negedge clk) begin
		if (rd_pend) begin
			em = exp_q.pop_front();
			`CHK(rd_data, em)
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	initial begin
		for (int k = 0; k < 4; k++) periph_drive[k] <= '{data: $random(seed), oe: $random(seed), ie: $random(seed)};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(pa(`PORT_DATA), `RST_WORD);
		rd(pa(`PORT_DIR), `RST_WORD);
		rd(ga(`IRQ_ASSIGN), {24'h00_0000, `RST_ASSIGN});
		rd(ca(4'h2, `IRQ_ASSIGN), {24'h00_0000, `RST_ASSIGN});
		rd({4'h5, `PORT_DATA}, 32'h0000_0000);
		d = $random(seed);
		wr(pa(`PORT_DATA), d);
		wr(pa(`PORT_DATA_SET), 32'h0000_0003);
		wr(pa(`PORT_DATA_CLR), 32'h0000_0130);
		wr(pa(`PORT_DATA_TGL), 32'h0000_0201);
		d = ((d | 32'h3) & ~32'h130) ^ 32'h201;
		rd(pa(`PORT_DATA_TGL), d);
		wr(pa(`PORT_DIR_SET), 32'h0000_FFFF);
		wr(pa(`PORT_DIR_CLR), 32'h0000_0C00);
		rd(pa(`PORT_DIR), 32'h0000_F3FF);
		settle();
		`CHK(pad_oe, 32'h0000_F3FF)
		`CHK(pad_out & pad_oe, d & 32'h0000_F3FF)
		ext_fight <= 32'h0000_00FF;
		ext_level <= ~d & 32'h0000_00FF;
		wr(pa(`PORT_INEN), 32'h0000_000F);
		settle();
		rd(pa(`PORT_PIN_STATE), (d & 32'h0000_F30F) | (~d & 32'h0000_00F0));
		rd(ga(`IRQ_PIN_STATE), (d & 32'h0000_F30F) | (~d & 32'h0000_00F0));
		wr(ga(`IRQ_EDGE_SET), 32'h0005_0001);
		wr(ga(`IRQ_BOTH_SET), 32'h0004_0000);
		wr(ga(`IRQ_POL_SET), 32'h0002_0000);
		ext_level <= ext_level | 32'h0005_0000;
		wr(pa(`PORT_DATA_TGL), 32'h0000_0001);
		settle();
		rd(ga(`IRQ_LATCH), 32'h0007_0000);
		ext_level <= (ext_level & ~32'h0005_0000) | 32'h0002_0000;
		settle();
		rd(ga(`IRQ_LATCH), 32'h0005_0000);
		rd(ga(`IRQ_REQ), 32'h0000_0000);
		#1;
		`CHK(gpio_irq, 1'b0)
		wr(ga(`IRQ_LATCH), 32'h0005_0000);
		rd(ga(`IRQ_LATCH), 32'h0000_0000);
		wr(ga(`IRQ_MASK_SET), 32'hFFFF_FFFF);
		wr(ga(`IRQ_SW_TRIG), 32'h0000_0001);
		settle();
		`CHK(gpio_irq, 1'b1)
		rd(ga(`IRQ_REQ), 32'h0000_0001);
		rd(ga(`IRQ_MASK), 32'hFFFF_FFFF);
		wr(ga(`IRQ_MASK_CLR), 32'hFFFF_FFFF);
		rd(ga(`IRQ_LATCH), 32'h0000_0001);
		settle();
		`CHK(gpio_irq, 1'b0)
		wr(ca(4'h1, `IRQ_EDGE_SET), 32'h0000_0100);
		wr(ca(4'h1, `IRQ_MASK_SET), 32'h0000_0100);
		wr(pa(`PORT_DATA_SET), 32'h0000_0100);
		settle();
		rd(ca(4'h1, `IRQ_REQ), 32'h0000_0100);
		`CHK(chan_irq, 3'b010)
		wr(ca(4'h1, `IRQ_REQ), 32'h0000_0100);
		settle();
		`CHK(chan_irq, 3'b000)
		wr(ca(4'h0, `IRQ_ASSIGN), 32'h0000_00E6);
		rd(ca(4'h0, `IRQ_ASSIGN), 32'h0000_00E6);
		wr(ca(4'h0, `IRQ_EDGE_SET), 32'h0000_0001);
		wr(ca(4'h0, `IRQ_MASK_SET), 32'h0000_0001);
		ext_level <= ext_level | 32'h0001_0000;
		settle();
		rd(ca(4'h0, `IRQ_REQ), 32'h0000_0001);
		`CHK(chan_irq, 3'b001)
		x = $random(seed);
		periph_drive[2] <= '{data: '0, oe: '0, ie: '1};
		periph_drive[3] <= '{data: x, oe: 32'h0100_0000, ie: '0};
		wr(pa(`PORT_FUNC_EN), 32'h0110_0000);
		wr(pa(`PORT_MUX_HI), 32'h0003_0200);
		ext_level <= ext_level | 32'h0010_0000;
		settle();
		`CHK(periph_in[2][20], 1'b1)
		`CHK({pad_oe[24], pad_out[24]}, {1'b1, x[24]})
		wr(pa(`PORT_MUX_LO), x);
		rd(pa(`PORT_MUX_LO), x);
		wr(ga(`IRQ_EDGE_CLR), 32'h0004_0000);
		rd(ga(`IRQ_EDGE_SET), 32'h0001_0001);
		settle();
		print_verdict();
	end
endmodule

bind gpio_port gpio_port_checker #(.CHAN_COUNT(CHAN_COUNT)) u_checker (.clk(clk), .rst(rst), .addr(addr),
	.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pad_out(pad_out),
	.pad_oe(pad_oe), .periph_in(periph_in), .gpio_irq(gpio_irq));
